// ### src/ssc_pkg.sv
// Package for the sense status capture block: offsets, fields, codes
package ssc_pkg;

	// ****************************************************
	// Register offsets (byte index of each sense byte)
	// ****************************************************
	localparam logic [7:0] SSC_OFF_TOGGLE   = 8'h13;
	localparam logic [7:0] SSC_OFF_CHECK    = 8'h14;
	localparam logic [7:0] SSC_OFF_PHYS_ID  = 8'h15;
	localparam logic [7:0] SSC_OFF_SYMPTOM  = 8'h16;
	// Low byte of the symptom code sits right after the high byte
	localparam logic [7:0] SSC_OFF_SYMP_LO  = 8'h17;

	// ****************************************************
	// Toggle status byte field positions
	// ****************************************************
	localparam int SSC_BIT_CHAN_PTR   = 0;
	localparam int SSC_BIT_DEV_PTR    = 1;
	localparam int SSC_BIT_ARITH_PTR  = 2;
	localparam int SSC_BIT_CARD_SEL   = 3;
	localparam int SSC_BIT_HIGH_SPEED = 5;
	localparam int SSC_BIT_STAGE1_FUL = 6;
	localparam int SSC_BIT_STAGE2_EMP = 7;

	// ****************************************************
	// Reset values
	// ****************************************************
	localparam logic [7:0]  SSC_RST_BYTE  = 8'h00;
	localparam logic [15:0] SSC_RST_WORD  = 16'h0000;

	// ****************************************************
	// Check classification codes
	// ****************************************************
	typedef enum logic [7:0] {
		SSC_CODE_NONE         = 8'h00,
		SSC_CODE_EARLY_END    = 8'h01,
		SSC_CODE_SEL_LOST     = 8'h02,
		SSC_CODE_TAG_SEQ      = 8'h10,
		SSC_CODE_BUS_PARITY   = 8'h20,
		SSC_CODE_UNEXP_L2     = 8'hC2,
		SSC_CODE_CMD_OVERRUN  = 8'hC7,
		SSC_CODE_DEV_PTR      = 8'hC8,
		SSC_CODE_CHAN_PTR     = 8'hC9,
		SSC_CODE_CRC_TO_DEV   = 8'hCA,
		SSC_CODE_CRC_TO_CHAN  = 8'hCB,
		SSC_CODE_TIMEOUT      = 8'hCC,
		SSC_CODE_AUX_NO_RESP  = 8'hCD,
		SSC_CODE_DCHK_RETRY   = 8'hD8,
		SSC_CODE_OVR_RETRY    = 8'hD9
	} ssc_code_type;

	// ****************************************************
	// Event index (one bit per check source, lowest wins)
	// ****************************************************
	localparam int SSC_EV_EARLY_END   = 0;
	localparam int SSC_EV_SEL_LOST    = 1;
	localparam int SSC_EV_TAG_SEQ     = 2;
	localparam int SSC_EV_BUS_PARITY  = 3;
	localparam int SSC_EV_UNEXP_L2    = 4;
	localparam int SSC_EV_CMD_OVERRUN = 5;
	localparam int SSC_EV_CRC_TO_DEV  = 6;
	localparam int SSC_EV_CRC_TO_CHAN = 7;
	localparam int SSC_EV_TIMEOUT     = 8;
	localparam int SSC_EV_AUX_NO_RESP = 9;
	localparam int SSC_EV_DCHK_RETRY  = 10;
	localparam int SSC_EV_OVR_RETRY   = 11;
	localparam int SSC_EV_COUNT       = 12;

	// Model variant selector
	localparam logic SSC_VARIANT_A = 1'b0;
	localparam logic SSC_VARIANT_B = 1'b1;

	// ****************************************************
	// Carriers
	// ****************************************************
	typedef struct packed {
		logic chan_ptr_high;
		logic dev_ptr_high;
		logic arith_ptr_high;
		logic high_speed;
		logic stage1_full;
		logic stage2_empty;
	} ssc_live_type;

	typedef struct packed {
		logic       parity_check;
		logic [1:0] array_addr;
	} ssc_parity_type;

	typedef struct packed {
		logic       xfer_end;
		logic [7:0] dev_ptr;
		logic [7:0] dev_ptr_exp;
		logic [7:0] chan_ptr;
		logic [7:0] chan_ptr_exp;
	} ssc_xfer_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ssc_bus_type;

endpackage : ssc_pkg

// ### src/ssc_sense_capture.sv
// Read-only diagnostic sense bytes of the storage director
// Overview of operation
// - Toggle bit 0 shows channel-side pointer half: 0 low, 1 high.
// - Toggle bit 1 shows device-side pointer half: 0 low, 1 high.
// - Toggle bit 2 shows arithmetic pointer half: 0 low, 1 high.
// - Bit 3 captures array address bit 1 on parity check; bit 4 unused.
// - Bit 5 set while selected channel is high speed.
// - Bit 6 set while first staging register holds a byte.
// - Bit 7 set while second staging register is empty.
// - Byte 20 holds code classifying the microcode detected check.
// - Variant A only: 01 early end, 02 selection lost.
// - Variant B only: 10 bad tag sequence, 20 bus-out parity.
// - Code C2 on an unexpected level 2 interrupt.
// - Code C7 on control command overrun during transfer.
// - At transfer end, pointer mismatches give C8 device, C9 channel.
// - CRC mismatch to device gives CA, to channel gives CB.
// - Code CC on timeout waiting for device interface process.
// - Code CD when auxiliary processor fails to answer a search.
// - Failed data check retry gives D8, failed overrun retry D9.
// - Byte 21 returns switch-sampled physical identifier when addressed.
// - Bytes 22 and 23 return the symptom code.
`timescale 1ns/1ps

module ssc_sense_capture (
	// Clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_reset_n,
	// Configuration
	input  wire logic                  i_variant,
	// Live status and fault sources
	input  wire ssc_pkg::ssc_live_type   i_live,
	input  wire ssc_pkg::ssc_parity_type i_parity,
	input  wire ssc_pkg::ssc_xfer_type   i_xfer,
	input  wire logic [ssc_pkg::SSC_EV_COUNT-1:0] i_check_event,
	// Identifier switches and symptom code
	input  wire logic [7:0]            i_id_switches,
	input  wire logic                  i_symptom_load,
	input  wire logic [15:0]           i_symptom,
	// Register port
	input  wire ssc_pkg::ssc_bus_type  i_bus,
	output logic [7:0]                 o_rdata,
	output logic                       o_check_valid
);
	import ssc_pkg::*;

	// ****************************************************
	// State
	// ****************************************************
	logic [7:0]   toggle_reg;
	logic [7:0]   toggle_next;
	logic         card_sel_reg;
	ssc_code_type check_code_reg;
	ssc_code_type check_code_next;
	logic         check_hit;
	logic         check_valid_reg;
	logic [15:0]  symptom_reg;
	logic [7:0]   rdata_reg;

	// ****************************************************
	// Toggle and fault isolation byte
	// ****************************************************

	// Card select latch, held until the next parity check
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			card_sel_reg <= 1'b0;
		end else if (i_parity.parity_check) begin
			card_sel_reg <= i_parity.array_addr[1];
		end
	end

	// Assemble the byte; bit 4 stays zero
	always_comb begin
		toggle_next = SSC_RST_BYTE;
		toggle_next[SSC_BIT_CHAN_PTR]   = i_live.chan_ptr_high;
		toggle_next[SSC_BIT_DEV_PTR]    = i_live.dev_ptr_high;
		toggle_next[SSC_BIT_ARITH_PTR]  = i_live.arith_ptr_high;
		toggle_next[SSC_BIT_CARD_SEL]   = card_sel_reg;
		toggle_next[SSC_BIT_HIGH_SPEED] = i_live.high_speed;
		toggle_next[SSC_BIT_STAGE1_FUL] = i_live.stage1_full;
		toggle_next[SSC_BIT_STAGE2_EMP] = i_live.stage2_empty;
	end

	// Registered so reads see one settled snapshot
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			toggle_reg <= SSC_RST_BYTE;
		end else begin
			toggle_reg <= toggle_next;
		end
	end

	// ****************************************************
	// Microcode check classification
	// ****************************************************

	// Fixed priority: transfer-end pointer checks, then event order
	always_comb begin
		check_code_next = SSC_CODE_NONE;
		check_hit       = 1'b1;
		if (i_xfer.xfer_end && (i_xfer.dev_ptr != i_xfer.dev_ptr_exp)) begin
			check_code_next = SSC_CODE_DEV_PTR;
		end else if (i_xfer.xfer_end &&
			(i_xfer.chan_ptr != i_xfer.chan_ptr_exp)) begin
			check_code_next = SSC_CODE_CHAN_PTR;
		end else if (i_variant == SSC_VARIANT_A &&
			i_check_event[SSC_EV_EARLY_END]) begin
			check_code_next = SSC_CODE_EARLY_END;
		end else if (i_variant == SSC_VARIANT_A &&
			i_check_event[SSC_EV_SEL_LOST]) begin
			check_code_next = SSC_CODE_SEL_LOST;
		end else if (i_variant == SSC_VARIANT_B &&
			i_check_event[SSC_EV_TAG_SEQ]) begin
			check_code_next = SSC_CODE_TAG_SEQ;
		end else if (i_variant == SSC_VARIANT_B &&
			i_check_event[SSC_EV_BUS_PARITY]) begin
			check_code_next = SSC_CODE_BUS_PARITY;
		end else if (i_check_event[SSC_EV_UNEXP_L2]) begin
			check_code_next = SSC_CODE_UNEXP_L2;
		end else if (i_check_event[SSC_EV_CMD_OVERRUN]) begin
			check_code_next = SSC_CODE_CMD_OVERRUN;
		end else if (i_check_event[SSC_EV_CRC_TO_DEV]) begin
			check_code_next = SSC_CODE_CRC_TO_DEV;
		end else if (i_check_event[SSC_EV_CRC_TO_CHAN]) begin
			check_code_next = SSC_CODE_CRC_TO_CHAN;
		end else if (i_check_event[SSC_EV_TIMEOUT]) begin
			check_code_next = SSC_CODE_TIMEOUT;
		end else if (i_check_event[SSC_EV_AUX_NO_RESP]) begin
			check_code_next = SSC_CODE_AUX_NO_RESP;
		end else if (i_check_event[SSC_EV_DCHK_RETRY]) begin
			check_code_next = SSC_CODE_DCHK_RETRY;
		end else if (i_check_event[SSC_EV_OVR_RETRY]) begin
			check_code_next = SSC_CODE_OVR_RETRY;
		end else begin
			check_hit = 1'b0;
		end
	end

	// Latest check wins; code holds until the next one
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			check_code_reg  <= SSC_CODE_NONE;
			check_valid_reg <= 1'b0;
		end else if (check_hit) begin
			check_code_reg  <= check_code_next;
			check_valid_reg <= 1'b1;
		end
	end

	// ****************************************************
	// Identifier and symptom code
	// ****************************************************

	// Symptom code loaded by the storage control
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			symptom_reg <= SSC_RST_WORD;
		end else if (i_symptom_load) begin
			symptom_reg <= i_symptom;
		end
	end

	// ****************************************************
	// Read port
	// ****************************************************

	// Identifier read samples the switches at the read strobe itself
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_reg <= SSC_RST_BYTE;
		end else if (i_bus.rd) begin
			unique case (i_bus.addr)
				SSC_OFF_TOGGLE:  rdata_reg <= toggle_reg;
				SSC_OFF_CHECK:   rdata_reg <= check_code_reg;
				SSC_OFF_PHYS_ID: rdata_reg <= i_id_switches;
				SSC_OFF_SYMPTOM: rdata_reg <= symptom_reg[15:8];
				SSC_OFF_SYMP_LO: rdata_reg <= symptom_reg[7:0];
				default:         rdata_reg <= SSC_RST_BYTE;
			endcase
		end else begin
			rdata_reg <= SSC_RST_BYTE;
		end
	end

	assign o_rdata       = rdata_reg;
	assign o_check_valid = check_valid_reg;

endmodule : ssc_sense_capture

// ### dv/ssc_sense_assertions.sv
// Checker for the sense status capture block
`timescale 1ns/1ps

module ssc_sense_assertions
	import ssc_pkg::*;
(
	// Clock and reset
	input wire logic                    i_sys_clk,
	input wire logic                    i_reset_n,
	// Watched inputs
	input wire logic                    i_variant,
	input wire ssc_pkg::ssc_xfer_type   i_xfer,
	input wire logic [SSC_EV_COUNT-1:0] i_check_event,
	input wire logic [7:0]              i_id_switches,
	input wire ssc_pkg::ssc_bus_type    i_bus,
	// Watched outputs
	input wire logic [7:0]              o_rdata,
	input wire logic                    o_check_valid
);
	// Decoded causes, kept as plain nets
	wire logic rd_code = i_bus.rd && (i_bus.addr == SSC_OFF_CHECK);
	wire logic dev_bad = i_xfer.dev_ptr != i_xfer.dev_ptr_exp;
	wire logic chan_bad = i_xfer.chan_ptr != i_xfer.chan_ptr_exp;
	// No check source active, so the latched code cannot move
	wire logic quiet = !i_xfer.xfer_end && !(|i_check_event);

	// ****************************************************
	// Properties
	// ****************************************************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);

	a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
		else $error("read data not zero outside answer cycle");
	a_unmapped_zero: assert property ($past(i_bus.rd &&
		(i_bus.addr < SSC_OFF_TOGGLE || i_bus.addr > 8'h17)) |-> !o_rdata)
		else $error("unmapped read not zero");
	a_spare_bit: assert property ($past(i_bus.rd &&
		i_bus.addr == SSC_OFF_TOGGLE) |-> !o_rdata[4])
		else $error("toggle bit 4 not zero");
	a_phys_id: assert property ($past(i_bus.rd &&
		i_bus.addr == SSC_OFF_PHYS_ID) |-> o_rdata == $past(i_id_switches))
		else $error("identifier differs from switches");
	a_dev_ptr: assert property (i_xfer.xfer_end && dev_bad ##1 quiet
		##1 rd_code |=> o_rdata == 8'hC8)
		else $error("device pointer code wrong");
	a_chan_ptr: assert property (i_xfer.xfer_end && !dev_bad && chan_bad
		##1 quiet ##1 rd_code |=> o_rdata == 8'hC9)
		else $error("channel code wrong");
	a_unexp_int: assert property (i_check_event == 12'h010
		&& !i_xfer.xfer_end ##1 quiet[*3] ##1 rd_code
		|=> o_rdata == 8'hC2)
		else $error("interrupt code wrong");
	a_early_end: assert property (i_check_event == 12'h001 && !i_variant
		&& !i_xfer.xfer_end ##1 quiet[*3] ##1 rd_code
		|=> o_rdata == 8'h01)
		else $error("early end code wrong");
	a_valid_hold: assert property (o_check_valid |=> o_check_valid)
		else $error("check valid dropped");
	a_valid_cause: assert property ($rose(o_check_valid) |->
		$past(|i_check_event || i_xfer.xfer_end, 2) ||
		$past(|i_check_event || i_xfer.xfer_end))
		else $error("check valid rose without a check");
endmodule : ssc_sense_assertions

bind ssc_sense_capture ssc_sense_assertions i_chk (
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_variant(i_variant),
	.i_xfer(i_xfer), .i_check_event(i_check_event),
	.i_id_switches(i_id_switches), .i_bus(i_bus), .o_rdata(o_rdata),
	.o_check_valid(o_check_valid)
);

// ### dv/ssc_sense_capture_tb.sv
// Self-checking bench for the sense status capture block
`timescale 1ns/1ps

module ssc_sense_capture_tb;
	import ssc_pkg::*;
	// Stimulus, outputs and scoreboard
	logic                    i_sys_clk = 1'h0;
	logic                    i_reset_n = 1'h0;
	logic                    i_variant = 1'h0;
	ssc_live_type            i_live = '0;
	ssc_parity_type          i_parity = '0;
	ssc_xfer_type            i_xfer = '0;
	logic [SSC_EV_COUNT-1:0] i_check_event = '0;
	logic [7:0]              i_id_switches = 8'h00;
	logic                    i_symptom_load = 1'h0;
	logic [15:0]             i_symptom = 16'h0000;
	ssc_bus_type             i_bus = '0;
	logic [7:0]              o_rdata;
	logic                    o_check_valid;
	logic [7:0]              exp_q[$];
	string                   name_q[$];
	logic                    rd_seen = 1'h0;
	int                      error_cnt = 0;
	int                      tests_run = 0;
	int                      seed = 35;
	logic [7:0]              code_tab[SSC_EV_COUNT] = '{8'h01, 8'h02,
		8'h10, 8'h20, 8'hC2, 8'hC7, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD8, 8'hD9};

	always #10 i_sys_clk = ~i_sys_clk;

	ssc_sense_capture i_dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
		.i_variant(i_variant), .i_live(i_live), .i_parity(i_parity),
		.i_xfer(i_xfer), .i_check_event(i_check_event),
		.i_id_switches(i_id_switches), .i_symptom_load(i_symptom_load),
		.i_symptom(i_symptom), .i_bus(i_bus), .o_rdata(o_rdata),
		.o_check_valid(o_check_valid));

	// Answer stands one cycle after the strobe, so compare it there
	always @(posedge i_sys_clk) begin
		rd_seen <= i_bus.rd;
		if (rd_seen) begin
			tests_run++;
			if (o_rdata !== exp_q[0]) begin
				error_cnt++;
				$display("FAIL %s exp %h got %h", name_q[0], exp_q[0], o_rdata);
			end
			void'(exp_q.pop_front());
			void'(name_q.pop_front());
		end
	end

	// ****************************************************
	// Bus and event tasks
	// ****************************************************
	task automatic rd(input logic [7:0] a, input logic [7:0] e, string n);
		@(posedge i_sys_clk);
		i_bus.addr <= a;
		i_bus.rd <= 1'h1;
		exp_q.push_back(e);
		name_q.push_back(n);
		@(posedge i_sys_clk);
		i_bus.rd <= 1'h0;
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_bus.addr <= a;
		i_bus.wdata <= d;
		i_bus.wr <= 1'h1;
		@(posedge i_sys_clk);
		i_bus.wr <= 1'h0;
	endtask : wr

	// Event pulse, then a write that must not disturb the code
	task automatic ev(input int b, input logic [7:0] e);
		@(posedge i_sys_clk);
		i_check_event <= 12'h001 << b;
		@(posedge i_sys_clk);
		i_check_event <= '0;
		wr(SSC_OFF_CHECK, 8'($random(seed)));
		rd(SSC_OFF_CHECK, e, "check code");
	endtask : ev

	// Transfer end against an expected value of 40 on both pointers
	task automatic xf(input logic [7:0] dp, cp, e);
		@(posedge i_sys_clk);
		i_xfer <= {1'h1, dp, 8'h40, cp, 8'h40};
		@(posedge i_sys_clk);
		i_xfer.xfer_end <= 1'h0;
		rd(SSC_OFF_CHECK, e, "pointer code");
	endtask : xf

	task automatic end_of_test();
		repeat (2) @(posedge i_sys_clk);
		// Every queued read must have been answered
		if (exp_q.size() != 0) begin
			error_cnt++;
			$display("FAIL queue exp %0d got %0d", 0, exp_q.size());
		end
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_reset_n <= 1'h1;
		rd(SSC_OFF_CHECK, 8'h00, "code reset");
		tests_run++;
		if (o_check_valid !== 1'h0) begin
			error_cnt++;
			$display("FAIL check_valid exp 0 got %b", o_check_valid);
		end
		for (int k = 0; k < 8; k++) begin
			@(posedge i_sys_clk);
			i_live <= 6'($random(seed));
			i_parity <= {1'h1, 2'($random(seed))};
			i_id_switches <= 8'($random(seed));
			@(posedge i_sys_clk);
			i_parity.parity_check <= 1'h0;
			wr(SSC_OFF_TOGGLE, 8'($random(seed)));
			rd(SSC_OFF_TOGGLE, {i_live.stage2_empty, i_live.stage1_full,
				i_live.high_speed, 1'h0, i_parity.array_addr[1],
				i_live.arith_ptr_high, i_live.dev_ptr_high,
				i_live.chan_ptr_high}, "toggle");
			rd(SSC_OFF_PHYS_ID, i_id_switches, "ident");
		end
		// Symptom code split over two bytes, high first
		@(posedge i_sys_clk);
		i_symptom <= 16'($random(seed));
		i_symptom_load <= 1'h1;
		@(posedge i_sys_clk);
		i_symptom_load <= 1'h0;
		wr(SSC_OFF_SYMPTOM, 8'hFF);
		rd(SSC_OFF_SYMPTOM, i_symptom[15:8], "symptom high");
		rd(8'h17, i_symptom[7:0], "symptom low");
		// Every check source, variant chosen to accept it
		for (int b = 0; b < SSC_EV_COUNT; b++) begin
			i_variant <= (b == 2 || b == 3);
			ev(b, code_tab[b]);
		end
		tests_run++;
		if (o_check_valid !== 1'h1) begin
			error_cnt++;
			$display("FAIL check_valid exp 1 got %b", o_check_valid);
		end
		ev(3, 8'hD9);
		i_variant <= 1'h1;
		ev(0, 8'hD9);
		xf(8'h40, 8'h40, 8'hD9);
		xf(8'h41, 8'h40, 8'hC8);
		xf(8'h40, 8'h3F, 8'hC9);
		xf(8'h00, 8'h00, 8'hC8);
		foreach (code_tab[a]) begin
			rd(8'(a * 21 + (a > 0 ? 8'h18 : 8'h00)), 8'h00, "unmapped");
		end
		end_of_test();
	end
endmodule : ssc_sense_capture_tb
